/* logic/term_rx_pkg.sv */
package term_rx_pkg;

  // ==========================================================================
  // Timing: base tick divided from the system clock
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned BASE_TICK_HZ    = 880;
  localparam int unsigned UNIT_HZ         = 110;
  // Base tick period rounds down to whole cycles
  localparam int unsigned BASE_TICK_CYCLES = CLK_HZ / BASE_TICK_HZ;
  localparam int unsigned TICK_CNT_W      = 15;
  localparam int unsigned TICKS_PER_UNIT  = BASE_TICK_HZ / UNIT_HZ;
  localparam int unsigned PHASE_W         = 3;
  // Sample point half a unit after the frame arm
  localparam logic [2:0]  SAMPLE_PHASE    = 3'h3;
  localparam logic [2:0]  DIV_LAST        = 3'h7;

  // ==========================================================================
  // Character and buffering
  // ==========================================================================
  localparam int unsigned CHAR_BITS       = 8;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam logic [7:0]  SHREG_PRESET    = 8'hff;
  localparam logic [7:0]  SHREG_RESET     = 8'h00;

  typedef struct packed {
    logic [7:0] data;
  } rx_char_t;

  typedef struct packed {
    logic char_ready;
    logic tape_advance_release;
    logic rx_in_progress;
    logic rx_final_unit;
  } rx_status_t;

endpackage

/* logic/char_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module char_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_srst,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Flags: extra pointer bit tells full from empty
  // ==========================================================================
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign o_in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0])
                       || (wr_ptr[AW] == rd_ptr[AW]);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr[AW-1:0]];

  // Pointer advance
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  // Storage written only, never reset; pointers guard reads
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= i_in_data;
      end
    end
  end

endmodule

`default_nettype wire

/* logic/terminal_serial_receiver.sv */
// What this block does
// - 880 Hz base tick divided to 110 Hz units
// - Turn 11-unit serial frame into 8-bit character
// - Two stop units keep frame synchronization
// - Init clears activity, flag; sets tape release
// - Idle tick with start bit gives frame arm
// - Frame arm: in progress, preset ones, stop tape
// - Tape stops only between characters
// - Half-unit resample; no start bit aborts frame
// - Mid-bit shifts; first loads start zero
// - Shift after start at stage 7 ends frame
// - Final unit clears in progress, stops shifts
// - Divided ticks count two stop stages
// - Second stop stage rearms start detection
// - Ready flag drives interrupt request
// - Skip test with flag asserts skip line
// - At most ten characters per second
// - Receiver independent of transmitter
// - Keyboard and reader share one input
// - Flag clear: clear flag, release tape, clear acc
// - Read-keep gates character, flag kept
// - Read-clear does both in one cycle
`timescale 1ns/100ps
`default_nettype none

module terminal_serial_receiver #(
  parameter int unsigned BASE_TICK_CYCLES = term_rx_pkg::BASE_TICK_CYCLES
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_srst,
  input  wire logic            i_ce,
  input  wire logic            i_serial_line,
  input  wire logic            i_system_init_level,
  input  wire logic            i_flag_skip_test,
  input  wire logic            i_flag_clear_advance,
  input  wire logic            i_read_char_keep,
  input  wire logic            i_read_char_clear,
  input  wire logic            i_char_ready,
  output logic                 o_char_valid,
  output term_rx_pkg::rx_char_t o_char,
  output term_rx_pkg::rx_char_t o_bus_data,
  output logic                 o_bus_strobe,
  output logic                 o_accumulator_clear,
  output logic                 o_cpu_irq_request,
  output logic                 o_cpu_skip_line,
  output logic                 o_tape_advance_release,
  output term_rx_pkg::rx_status_t o_status
);

  // ==========================================================================
  // Line synchroniser
  // ==========================================================================
  logic line_meta;
  logic line_sync;

  // Line is asynchronous; only line_sync is ever examined
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else if (i_ce) begin
      line_meta <= i_serial_line;
      line_sync <= line_meta;
    end
  end

  // ==========================================================================
  // Base tick and divided tick
  // ==========================================================================
  logic [term_rx_pkg::TICK_CNT_W-1:0] tick_cnt;
  logic [term_rx_pkg::TICK_CNT_W-1:0] next_tick_cnt;
  logic [term_rx_pkg::PHASE_W-1:0]    div_cnt;
  logic [term_rx_pkg::PHASE_W-1:0]    next_div_cnt;
  logic                               rx_base_tick;
  logic                               divided_tick;

  assign rx_base_tick = (tick_cnt ==
    term_rx_pkg::TICK_CNT_W'(BASE_TICK_CYCLES - 1));
  assign divided_tick = rx_base_tick
                        && (div_cnt == term_rx_pkg::DIV_LAST);

  // Free running; never restarted by a frame. The receive divider is its
  // own, so transmit activity can never disturb the sampling grid
  always_comb begin
    next_tick_cnt = rx_base_tick ? '0 : tick_cnt + 1'b1;
    next_div_cnt  = rx_base_tick ? div_cnt + 1'b1 : div_cnt;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tick_cnt <= '0;
      div_cnt  <= '0;
    end else if (i_ce) begin
      tick_cnt <= next_tick_cnt;
      div_cnt  <= next_div_cnt;
    end
  end

  // ==========================================================================
  // Receiver control and shift register
  // ==========================================================================
  logic       rx_in_progress;
  logic       false_start_check;
  logic       rx_final_unit;
  logic       stop_count_first;
  logic       stop_count_second;
  logic       char_ready;
  logic       tape_advance_release;
  logic [2:0] phase;
  logic [7:0] shreg;
  logic       next_rx_in_progress;
  logic       next_false_start_check;
  logic       next_rx_final_unit;
  logic       next_stop_count_first;
  logic       next_stop_count_second;
  logic       next_char_ready;
  logic       next_tape_advance_release;
  logic [2:0] next_phase;
  logic [7:0] next_shreg;
  logic       start_detect_arm;
  logic       rx_frame_arm;
  logic       sample_slot;
  logic       false_abort;
  logic       rx_bit_shift;
  logic       last_shift;
  logic       flag_clear;
  logic       fifo_in_ready;
  term_rx_pkg::rx_char_t char_word;

  // Full buffer holds off the next frame: back-pressure on the line
  assign start_detect_arm = !rx_in_progress && !rx_final_unit
                            && fifo_in_ready;
  assign rx_frame_arm = start_detect_arm && rx_base_tick
                        && !line_sync && !i_system_init_level;
  assign sample_slot  = rx_in_progress && rx_base_tick
                        && (phase == term_rx_pkg::SAMPLE_PHASE);
  assign false_abort  = sample_slot && false_start_check && line_sync;
  assign rx_bit_shift = sample_slot && !false_abort;
  assign last_shift   = rx_bit_shift
                        && !shreg[term_rx_pkg::CHAR_BITS-1];
  assign flag_clear   = i_flag_clear_advance || i_read_char_clear;

  // Stage 7 holds the first data bit, so reverse into data order
  for (genvar b = 0; b < term_rx_pkg::CHAR_BITS; b++) begin : g_rev
    assign char_word.data[b] = shreg[term_rx_pkg::CHAR_BITS-1-b];
  end

  // Next state of the receiver
  always_comb begin
    next_rx_in_progress       = rx_in_progress;
    next_false_start_check    = false_start_check;
    next_rx_final_unit        = rx_final_unit;
    next_stop_count_first     = stop_count_first;
    next_stop_count_second    = stop_count_second;
    next_char_ready           = char_ready;
    next_tape_advance_release = tape_advance_release;
    next_phase                = phase;
    next_shreg                = shreg;
    // Phase counts base ticks from the frame arm
    if (rx_in_progress && rx_base_tick) begin
      next_phase = phase + 1'b1;
    end
    if (rx_frame_arm) begin
      next_rx_in_progress       = 1'b1;
      next_false_start_check    = 1'b1;
      next_shreg                = term_rx_pkg::SHREG_PRESET;
      next_tape_advance_release = 1'b0;
      next_phase                = '0;
    end
    if (false_abort) begin
      next_rx_in_progress    = 1'b0;
      next_false_start_check = 1'b0;
    end
    if (rx_bit_shift) begin
      next_false_start_check = 1'b0;
      next_shreg = {shreg[term_rx_pkg::CHAR_BITS-2:0], line_sync};
    end
    if (last_shift) begin
      next_rx_final_unit  = 1'b1;
      next_rx_in_progress = 1'b0;
    end
    // Stop time counted only once shifting has ended
    if (!rx_in_progress && rx_final_unit && divided_tick) begin
      if (!stop_count_first) begin
        next_stop_count_first = 1'b1;
      end else begin
        next_stop_count_second = 1'b1;
      end
    end
    if (stop_count_second) begin
      next_rx_final_unit     = 1'b0;
      next_stop_count_first  = 1'b0;
      next_stop_count_second = 1'b0;
    end
    // A clear in the same cycle as the set loses the race
    if (flag_clear) begin
      next_char_ready = 1'b0;
      if (!rx_frame_arm) begin
        next_tape_advance_release = 1'b1;
      end
    end
    if (last_shift) begin
      next_char_ready = 1'b1;
    end
    if (i_system_init_level) begin
      next_rx_in_progress       = 1'b0;
      next_false_start_check    = 1'b0;
      next_char_ready           = 1'b0;
      next_tape_advance_release = 1'b1;
      next_rx_final_unit        = 1'b0;
      next_stop_count_first     = 1'b0;
      next_stop_count_second    = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_in_progress       <= 1'b0;
      false_start_check    <= 1'b0;
      rx_final_unit        <= 1'b0;
      stop_count_first     <= 1'b0;
      stop_count_second    <= 1'b0;
      char_ready           <= 1'b0;
      tape_advance_release <= 1'b1;
      phase                <= '0;
      shreg                <= term_rx_pkg::SHREG_RESET;
    end else if (i_ce) begin
      rx_in_progress       <= next_rx_in_progress;
      false_start_check    <= next_false_start_check;
      rx_final_unit        <= next_rx_final_unit;
      stop_count_first     <= next_stop_count_first;
      stop_count_second    <= next_stop_count_second;
      char_ready           <= next_char_ready;
      tape_advance_release <= next_tape_advance_release;
      phase                <= next_phase;
      shreg                <= next_shreg;
    end
  end

  // ==========================================================================
  // Processor side: bus gating, skip, interrupt
  // ==========================================================================
  term_rx_pkg::rx_char_t next_bus_data;
  logic                  next_bus_strobe;
  logic                  next_accumulator_clear;

  // Bus reads zero unless a read instruction gates the character
  always_comb begin
    next_bus_data          = '0;
    next_bus_strobe        = i_read_char_keep || i_read_char_clear;
    next_accumulator_clear = flag_clear;
    if (next_bus_strobe) begin
      next_bus_data = char_word;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_bus_data          <= '0;
      o_bus_strobe        <= 1'b0;
      o_accumulator_clear <= 1'b0;
    end else if (i_ce) begin
      o_bus_data          <= next_bus_data;
      o_bus_strobe        <= next_bus_strobe;
      o_accumulator_clear <= next_accumulator_clear;
    end
  end

  assign o_cpu_irq_request      = char_ready;
  assign o_cpu_skip_line        = i_flag_skip_test && char_ready;
  assign o_tape_advance_release = tape_advance_release;
  assign o_status = '{char_ready, tape_advance_release,
                      rx_in_progress, rx_final_unit};

  // ==========================================================================
  // Character stream buffer, fed at the end of each frame
  // ==========================================================================
  logic [7:0] fifo_out;

  char_fifo #(
    .WIDTH (term_rx_pkg::CHAR_BITS),
    .DEPTH (term_rx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .i_ce        (i_ce),
    .i_in_valid  (last_shift),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({shreg[term_rx_pkg::CHAR_BITS-2:0], line_sync}),
    .o_out_valid (o_char_valid),
    .i_out_ready (i_char_ready),
    .o_out_data  (fifo_out)
  );

  // Assembled order is stage 7 first; reverse into data order
  for (genvar b = 0; b < term_rx_pkg::CHAR_BITS; b++) begin : g_out
    assign o_char.data[b] = fifo_out[term_rx_pkg::CHAR_BITS-1-b];
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_arm_state;
    rx_in_progress && false_start_check && !tape_advance_release
    && (shreg == 8'hff);
  endsequence

  sequence s_end_state;
    rx_final_unit && char_ready && !rx_in_progress;
  endsequence

  property p_init_clears;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_system_init_level && i_ce) |=> (!rx_in_progress
      && !false_start_check && !char_ready && tape_advance_release);
  endproperty
  a_init_clears: assert property (p_init_clears)
    else $error("init did not clear receiver");

  property p_arm_cause;
    @(posedge i_clk_sys) disable iff (i_srst)
    rx_frame_arm |-> (!rx_in_progress && !rx_final_unit && rx_base_tick
      && !line_sync);
  endproperty
  a_arm_cause: assert property (p_arm_cause)
    else $error("frame arm without idle tick and start bit");

  property p_arm_effect;
    @(posedge i_clk_sys) disable iff (i_srst)
    (rx_frame_arm && i_ce) |=> s_arm_state;
  endproperty
  a_arm_effect: assert property (p_arm_effect)
    else $error("frame arm did not preset receiver");

  property p_false_start;
    @(posedge i_clk_sys) disable iff (i_srst)
    (false_start_check && sample_slot && line_sync && i_ce
      && !rx_frame_arm) |=> (!rx_in_progress && (shreg == $past(shreg)));
  endproperty
  a_false_start: assert property (p_false_start)
    else $error("false start not aborted");

  property p_first_shift;
    @(posedge i_clk_sys) disable iff (i_srst)
    (rx_bit_shift && false_start_check && i_ce
      && !i_system_init_level) |=> (!shreg[0] && rx_in_progress);
  endproperty
  a_first_shift: assert property (p_first_shift)
    else $error("first shift did not load start zero");

  property p_frame_end;
    @(posedge i_clk_sys) disable iff (i_srst)
    (rx_bit_shift && !shreg[7] && i_ce && !i_system_init_level)
      |=> s_end_state;
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("frame did not end after start reached stage 7");

  property p_stop_release;
    @(posedge i_clk_sys) disable iff (i_srst)
    (stop_count_second && i_ce) |=> (!rx_final_unit && !stop_count_first);
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("second stop stage did not rearm");

  property p_skip;
    @(posedge i_clk_sys) disable iff (i_srst)
    i_flag_skip_test |-> (o_cpu_skip_line == char_ready);
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip line wrong during skip test");

  property p_read;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_read_char_keep && !i_read_char_clear && !i_flag_clear_advance
      && !last_shift && !i_system_init_level && i_ce)
      |=> (o_bus_strobe && (o_bus_data == $past(char_word))
      && (char_ready == $past(char_ready)));
  endproperty
  a_read: assert property (p_read)
    else $error("read-keep did not gate character");

  property p_char_hold;
    @(posedge i_clk_sys) disable iff (i_srst)
    (char_ready && !rx_in_progress && !rx_frame_arm && i_ce)
      |=> (shreg == $past(shreg));
  endproperty
  a_char_hold: assert property (p_char_hold)
    else $error("character changed before next frame arm");

  property p_tick_gap;
    @(posedge i_clk_sys) disable iff (i_srst)
    (rx_base_tick && i_ce) |=> !rx_base_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("base ticks too close");

endmodule

`default_nettype wire

/* tb/term_line_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Terminal line model: keyboard and tape reader share this one line
// ============================================================================
module term_line_model #(
  parameter int unsigned UNIT_CYCLES = 128
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_send,
  input  wire logic [7:0] i_tx_char,
  input  wire logic       i_spike,
  output logic            o_line,
  output logic            o_busy
);
  logic [10:0] frame;
  int          k;

  // Line rests at mark between frames. Start space, data LSB first,
  // two mark stops; frame length caps rate. One process drives both pins
  initial begin
    o_line = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk_sys);
      if (i_send === 1'b1) begin
        o_busy <= 1'b1;
        frame = {2'b11, i_tx_char, 1'b0};
        for (k = 0; k < 11; k++) begin
          o_line <= frame[k];
          repeat (UNIT_CYCLES) @(posedge i_clk_sys);
        end
        o_busy <= 1'b0;
      end else if (i_spike === 1'b1) begin
        // Noise burst shorter than half a unit
        o_line <= 1'b0;
        repeat (UNIT_CYCLES / 4) @(posedge i_clk_sys);
        o_line <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

/* tb/tb_terminal_serial_receiver.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_terminal_serial_receiver;
  // Short tick keeps a frame near 1400 cycles
  localparam int unsigned TICK = 16;
  localparam int unsigned UNIT = TICK * term_rx_pkg::TICKS_PER_UNIT;

  logic                    clk, srst, line, init, skip, clr, keep, rdclr;
  logic                    rdy, send_req, spike, busy, char_valid, ce;
  logic                    bus_strobe, acc_clr, irq, skip_line, tape_rel;
  logic [7:0]              tx_char, c;
  logic [7:0]              q[$];
  term_rx_pkg::rx_char_t   rx_char, bus_data;
  term_rx_pkg::rx_status_t status;
  int                      errors, tests_run, seed, n, bad;

  // ==========================================================================
  // Clock, design and far side
  // ==========================================================================
  always #20 clk = ~clk;

  terminal_serial_receiver #(.BASE_TICK_CYCLES(TICK)) i_dut (
    .i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_serial_line(line),
    .i_system_init_level(init), .i_flag_skip_test(skip),
    .i_flag_clear_advance(clr), .i_read_char_keep(keep),
    .i_read_char_clear(rdclr), .i_char_ready(rdy),
    .o_char_valid(char_valid), .o_char(rx_char), .o_bus_data(bus_data),
    .o_bus_strobe(bus_strobe), .o_accumulator_clear(acc_clr),
    .o_cpu_irq_request(irq), .o_cpu_skip_line(skip_line),
    .o_tape_advance_release(tape_rel), .o_status(status));

  term_line_model #(.UNIT_CYCLES(UNIT)) i_line (
    .i_clk_sys(clk), .i_send(send_req), .i_tx_char(tx_char),
    .i_spike(spike), .o_line(line), .o_busy(busy));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Task-driven inputs move 2 ns after the rising edge; the line model drives the line on the edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Status as flag, release, in progress, final unit
  function automatic logic [7:0] st(input logic f, input logic r,
                                    input logic a, input logic l);
    return {4'h0, f, r, a, l};
  endfunction

  // Bounded wait: 0 line idle, 1 flag up, 2 final unit gone
  task automatic wait_for(input int which, input int limit);
    for (n = 0; n < limit; n++) begin
      if (which == 0 && busy === 1'b0) break;
      if (which == 1 && irq === 1'b1) break;
      if (which == 2 && status.rx_final_unit === 1'b0) break;
      step(1);
    end
    if (n == limit) begin
      errors++;
      close_out();
    end
  endtask

  task automatic send(input logic [7:0] ch);
    wait_for(0, 12 * UNIT);
    send_req = 1'b1;
    tx_char = ch;
    step(1);
    send_req = 1'b0;
  endtask

  // Instruction pulse: 0 clear, 1 read keep, 2 read clear
  task automatic instr(input int k);
    clr = (k == 0);
    keep = (k == 1);
    rdclr = (k == 2);
    step(1);
    clr = 1'b0;
    keep = 1'b0;
    rdclr = 1'b0;
  endtask

  task automatic drain(input logic [7:0] ch);
    check({7'h0, char_valid}, 8'h01);
    check(rx_char, ch);
    rdy = 1'b1;
    step(1);
    rdy = 1'b0;
  endtask

  // One character, serviced the way the processor would
  task automatic rx_one(input logic [7:0] ch, input logic rd_clear);
    send(ch);
    step(2 * UNIT);
    check({4'h0, status}, st(1'b0, 1'b0, 1'b1, 1'b0));
    wait_for(1, 10 * UNIT);
    step(1);
    check({4'h0, status}, st(1'b1, 1'b0, 1'b0, 1'b1));
    skip = 1'b1;
    #1;
    check({7'h0, skip_line}, 8'h01);
    step(1);
    skip = 1'b0;
    instr(1);
    check({6'h0, bus_strobe, irq}, 8'h03);
    check(bus_data, ch);
    instr(rd_clear ? 2 : 0);
    check({6'h0, bus_strobe, acc_clr}, {6'h0, rd_clear, 1'b1});
    check(bus_data, rd_clear ? ch : 8'h00);
    check({4'h0, status}, st(1'b0, 1'b1, 1'b0, 1'b1));
    skip = 1'b1;
    #1;
    check({7'h0, skip_line}, 8'h00);
    step(1);
    skip = 1'b0;
    wait_for(2, 3 * UNIT);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {init, skip, clr, keep, rdclr, rdy, send_req, spike} = 8'h00;
    ce = 1'b1;
    tx_char = 8'h00;
    errors = 0;
    tests_run = 0;
    seed = 62382;
    step(6);
    srst = 1'b0;
    check({4'h0, status}, st(1'b0, 1'b1, 1'b0, 1'b0));
    check({7'h0, char_valid}, 8'h00);
    // Corner values then random ones, back to back on the line
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'h01
        : 8'($random(seed));
      rx_one(c, i[0]);
      drain(c);
    end
    // Noise shorter than half a unit is dropped, tape stays held
    wait_for(0, 12 * UNIT);
    spike = 1'b1;
    step(1);
    spike = 1'b0;
    step(UNIT);
    check({4'h0, status}, st(1'b0, 1'b0, 1'b0, 1'b0));
    check({7'h0, char_valid}, 8'h00);
    instr(0);
    check({7'h0, tape_rel}, 8'h01);
    // Init level in mid-frame throws the character away
    send(8'hff);
    step(3 * UNIT);
    check({7'h0, status.rx_in_progress}, 8'h01);
    // Frozen design ignores the init level until enabled again
    ce = 1'b0;
    init = 1'b1;
    step(1);
    check({6'h0, status.rx_in_progress, tape_rel}, 8'h02);
    ce = 1'b1;
    step(1);
    init = 1'b0;
    check({4'h0, status}, st(1'b0, 1'b1, 1'b0, 1'b0));
    wait_for(0, 12 * UNIT);
    step(UNIT);
    check({6'h0, irq, char_valid}, 8'h00);
    // Fill the FIFO with nothing draining it
    for (int i = 0; i < term_rx_pkg::FIFO_DEPTH; i++) begin
      c = 8'($random(seed));
      q.push_back(c);
      rx_one(c, 1'b1);
    end
    // A full FIFO must hold off the next start bit for the whole frame
    send(8'h00);
    bad = 0;
    for (n = 0; n < 11 * UNIT; n++) begin
      if (status.rx_in_progress !== 1'b0) bad++;
      step(1);
    end
    check({7'h0, bad == 0}, 8'h01);
    while (q.size() > 0) drain(q.pop_front());
    check({7'h0, char_valid}, 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
